// ---- src/bridge_regs.svh ----
`ifndef BRIDGE_REGS_SVH
`define BRIDGE_REGS_SVH

// Register indices; byte address is four times the index
`define REG_PIN_TYPE_CONFIG      6'h00
`define REG_PIN_LEVEL            6'h01
`define REG_BUS_BIT_RATE_DIVIDER 6'h02
`define REG_TRANSFER_TIMEOUT     6'h03
`define REG_BUS_TRANSACTION_STAT 6'h04
`define REG_OWN_BUS_ADDRESS      6'h05

// Reset values
`define RST_PIN_TYPE_CONFIG      8'h00
`define RST_BUS_BIT_RATE_DIVIDER 8'h19
`define RST_TRANSFER_TIMEOUT     8'h00
`define RST_BUS_TRANSACTION_STAT 8'h00
`define RST_OWN_BUS_ADDRESS      8'h00

// Field layout
`define PIN_TYPE_PUSH_PULL       2'h2
`define PIN_TYPE_OPEN_DRAIN      2'h3
`define TIMEOUT_ENABLE_BIT       0
`define TIMEOUT_COUNT_MSB        7
`define TIMEOUT_COUNT_LSB        1
`define OWN_ADDR_MSB             7
`define OWN_ADDR_LSB             1
`define STATUS_TIMEOUT_CODE      8'hF8
`define PROG_PIN_COUNT           4
`define ALL_PIN_COUNT            5

// Timing
`define CLK_FREQ_HZ              100000000
`define REF_FREQ_HZ              15000000
`define REF_ACC_STEP             7'(`REF_FREQ_HZ / 1000000)
`define REF_ACC_WRAP             7'(`CLK_FREQ_HZ / 1000000)
`define TIMEOUT_UNIT_SHIFT       9
`define SCL_QUARTER_MULT         1
`define GLITCH_FILTER_LEN        3

`endif

// ---- src/bridge_pkg.sv ----
package bridge_pkg;

    typedef enum logic [0:0] {
        RETRY_IDLE,
        RETRY_WAIT_FREE
    } retry_state_t;

    typedef logic [1:0] pin_type_t;

endpackage

// ---- src/pin_input_filter.sv ----
`timescale 1ns/1ps
`include "bridge_regs.svh"

module pin_input_filter (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [`ALL_PIN_COUNT-1:0]  pin_raw,
    output logic      [`ALL_PIN_COUNT-1:0]  pin_clean
);

    genvar g;
    generate
        for (g = 0; g < `ALL_PIN_COUNT; g = g + 1) begin : g_pin
            logic                          meta_reg;
            logic                          sync_reg;
            logic [`GLITCH_FILTER_LEN-1:0] hist_reg;
            logic                          clean_reg;

            // Two-stage synchroniser; only the second stage is looked at
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end else begin
                    meta_reg <= pin_raw[g];
                    sync_reg <= meta_reg;
                end
            end

            // Level changes only after it has held for the whole window
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    hist_reg  <= '0;
                    clean_reg <= 1'b0;
                end else begin
                    hist_reg <= {hist_reg[`GLITCH_FILTER_LEN-2:0], sync_reg};
                    if (&hist_reg) begin
                        clean_reg <= 1'b1;
                    end else if (~|hist_reg) begin
                        clean_reg <= 1'b0;
                    end
                end
            end

            assign pin_clean[g] = clean_reg;
        end
    endgenerate

endmodule

// ---- src/spi_i2c_bridge_config_regs.sv ----
// Functional notes
// - Host serial port is SPI mode 3
// - Two-bit type field per pin 0..3
// - Pin 4 input only, writes ignored
// - Open-drain pulls low only for latch 0
// - Push-pull drives latch value strongly
// - Level read returns actual pin levels
// - Level write loads latches, reaches outputs
// - Own address in bits 7..1
// - Bus clock is 15 MHz over 8*divider
// - Timeout bit 0 enables timeout
// - Timeout (div+1)/15MHz*512*(1+field)
// - Timeout bounds one transfer, then aborts
// - After lost arbitration restart when free
// - Expiry asserts interrupt, posts timeout code
// - Timeout code reads as 0xF8
// - Interrupt released by status read, reset
`timescale 1ns/1ps
`include "bridge_regs.svh"

module spi_i2c_bridge_config_regs (
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Register bus, fed by the host serial front end
    input  wire logic                        wb_cyc,
    input  wire logic                        wb_stb,
    input  wire logic                        wb_we,
    input  wire logic [7:0]                  wb_adr,
    input  wire logic [31:0]                 wb_dat_w,
    input  wire logic [3:0]                  wb_sel,
    output logic      [31:0]                 wb_dat_r,
    output logic                             wb_ack,
    // Programmable pins
    input  wire logic [`ALL_PIN_COUNT-1:0]   pin_in,
    output logic      [`PROG_PIN_COUNT-1:0]  pin_out,
    output logic      [`PROG_PIN_COUNT-1:0]  pin_oe,
    output logic      [`PROG_PIN_COUNT-1:0]  pin_pullup_en,
    // Bus controller engine side
    input  wire logic                        xfer_active,
    input  wire logic                        arb_lost,
    input  wire logic                        bus_free,
    input  wire logic                        status_load,
    input  wire logic [7:0]                  status_code,
    input  wire logic                        status_irq,
    output logic                             restart_start,
    output logic                             timeout_abort,
    output logic                             scl_quarter_tick,
    output logic      [6:0]                  own_addr,
    // Interrupt, open drain, active low
    output logic                             int_n_out,
    output logic                             int_n_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic is_output(input bridge_pkg::pin_type_t t);
        is_output = t[1];
    endfunction

    function automatic logic is_open_drain(input bridge_pkg::pin_type_t t);
        is_open_drain = (t == `PIN_TYPE_OPEN_DRAIN);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0]                 pin_type_config_reg;
    logic [`PROG_PIN_COUNT-1:0] pin_latch_reg;
    logic [7:0]                 bit_rate_divider_reg;
    logic [7:0]                 transfer_timeout_reg;
    logic [7:0]                 status_reg;
    logic [6:0]                 own_addr_reg;
    logic                       int_pending_reg;
    logic                       ack_reg;
    logic [31:0]                dat_r_reg;
    logic [`ALL_PIN_COUNT-1:0]  pin_clean;
    logic                       access;
    logic                       wr_en;
    logic                       rd_en;
    logic [5:0]                 index;
    logic [6:0]                 ref_acc_reg;
    logic [6:0]                 ref_acc_sum;
    logic                       ref_tick_reg;
    logic [8:0]                 scl_cnt_reg;
    logic [8:0]                 scl_limit;
    logic                       scl_tick_reg;
    logic [7:0]                 unit_cnt_reg;
    logic [16:0]                to_cnt_reg;
    logic [16:0]                to_limit;
    logic                       timed_out_reg;
    logic                       timeout_en;
    logic                       abort_reg;
    logic                       restart_reg;
    logic                       int_set;
    bridge_pkg::retry_state_t   retry_state_reg;

    ////////////////////////////////////////////////////////////////////////
    // Register bus slave, one wait state

    // The mode-3 serial front end issues one access per decoded command
    assign access = wb_cyc & wb_stb & ~ack_reg;
    assign index  = wb_adr[7:2];
    assign wr_en  = access & wb_we & wb_sel[0];
    assign rd_en  = access & ~wb_we;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dat_r_reg <= 32'h00000000;
        end else if (rd_en) begin
            dat_r_reg <= 32'h00000000;
            if (index == `REG_PIN_TYPE_CONFIG) begin
                dat_r_reg[7:0] <= pin_type_config_reg;
            end else if (index == `REG_PIN_LEVEL) begin
                dat_r_reg[`ALL_PIN_COUNT-1:0] <= pin_clean;
            end else if (index == `REG_BUS_BIT_RATE_DIVIDER) begin
                dat_r_reg[7:0] <= bit_rate_divider_reg;
            end else if (index == `REG_TRANSFER_TIMEOUT) begin
                dat_r_reg[7:0] <= transfer_timeout_reg;
            end else if (index == `REG_BUS_TRANSACTION_STAT) begin
                dat_r_reg[7:0] <= status_reg;
            end else if (index == `REG_OWN_BUS_ADDRESS) begin
                dat_r_reg[7:0] <= {own_addr_reg, 1'b0};
            end
        end
    end

    assign wb_ack   = ack_reg;
    assign wb_dat_r = dat_r_reg;

    ////////////////////////////////////////////////////////////////////////
    // Software-written registers

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_type_config_reg  <= `RST_PIN_TYPE_CONFIG;
            bit_rate_divider_reg <= `RST_BUS_BIT_RATE_DIVIDER;
            transfer_timeout_reg <= `RST_TRANSFER_TIMEOUT;
            own_addr_reg         <= 7'(`RST_OWN_BUS_ADDRESS >> 1);
        end else if (wr_en) begin
            if (index == `REG_PIN_TYPE_CONFIG) begin
                pin_type_config_reg <= wb_dat_w[7:0];
            end else if (index == `REG_BUS_BIT_RATE_DIVIDER) begin
                bit_rate_divider_reg <= wb_dat_w[7:0];
            end else if (index == `REG_TRANSFER_TIMEOUT) begin
                transfer_timeout_reg <= wb_dat_w[7:0];
            end else if (index == `REG_OWN_BUS_ADDRESS) begin
                own_addr_reg <= wb_dat_w[`OWN_ADDR_MSB:`OWN_ADDR_LSB];
            end
        end
    end

    // Only the four programmable latches exist; bit 4 and up are dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_latch_reg <= '0;
        end else if (wr_en && index == `REG_PIN_LEVEL) begin
            pin_latch_reg <= wb_dat_w[`PROG_PIN_COUNT-1:0];
        end
    end

    assign own_addr = own_addr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers

    pin_input_filter u_filter (
        .clk       (clk),
        .rst       (rst),
        .pin_raw   (pin_in),
        .pin_clean (pin_clean)
    );

    genvar g;
    generate
        for (g = 0; g < `PROG_PIN_COUNT; g = g + 1) begin : g_drv
            bridge_pkg::pin_type_t t;
            assign t = pin_type_config_reg[2*g+1:2*g];
            // Open drain: only the pull-down, enabled while the latch is 0
            assign pin_out[g] = is_open_drain(t) ? 1'b0 : pin_latch_reg[g];
            assign pin_oe[g]  = is_open_drain(t) ? ~pin_latch_reg[g]
                              : is_output(t);
            assign pin_pullup_en[g] = ~is_open_drain(t);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // 15 MHz reference tick and bus clock rate

    assign ref_acc_sum = ref_acc_reg + `REF_ACC_STEP;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_acc_reg  <= 7'h00;
            ref_tick_reg <= 1'b0;
        end else if (ref_acc_sum >= `REF_ACC_WRAP) begin
            ref_acc_reg  <= ref_acc_sum - `REF_ACC_WRAP;
            ref_tick_reg <= 1'b1;
        end else begin
            ref_acc_reg  <= ref_acc_sum;
            ref_tick_reg <= 1'b0;
        end
    end

    // A quarter bus period is 2*divider reference ticks; zero is clamped
    assign scl_limit = (bit_rate_divider_reg == 8'h00) ? 9'h002
                     : {bit_rate_divider_reg, `SCL_QUARTER_MULT'(0)};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_cnt_reg  <= 9'h000;
            scl_tick_reg <= 1'b0;
        end else begin
            scl_tick_reg <= 1'b0;
            if (ref_tick_reg) begin
                if (scl_cnt_reg + 9'h001 >= scl_limit) begin
                    scl_cnt_reg  <= 9'h000;
                    scl_tick_reg <= 1'b1;
                end else begin
                    scl_cnt_reg <= scl_cnt_reg + 9'h001;
                end
            end
        end
    end

    assign scl_quarter_tick = scl_tick_reg;

    ////////////////////////////////////////////////////////////////////////
    // Transfer timeout

    assign timeout_en = transfer_timeout_reg[`TIMEOUT_ENABLE_BIT];
    assign to_limit   = {8'(transfer_timeout_reg[`TIMEOUT_COUNT_MSB:
                         `TIMEOUT_COUNT_LSB]) + 8'h01,
                         `TIMEOUT_UNIT_SHIFT'(0)};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unit_cnt_reg  <= 8'h00;
            to_cnt_reg    <= 17'h00000;
            timed_out_reg <= 1'b0;
            abort_reg     <= 1'b0;
        end else begin
            abort_reg <= 1'b0;
            if (!xfer_active || !timeout_en) begin
                unit_cnt_reg  <= 8'h00;
                to_cnt_reg    <= 17'h00000;
                timed_out_reg <= 1'b0;
            end else if (!timed_out_reg && ref_tick_reg) begin
                if (unit_cnt_reg == bit_rate_divider_reg) begin
                    unit_cnt_reg <= 8'h00;
                    if (to_cnt_reg + 17'h00001 == to_limit) begin
                        timed_out_reg <= 1'b1;
                        abort_reg     <= 1'b1;
                    end else begin
                        to_cnt_reg <= to_cnt_reg + 17'h00001;
                    end
                end else begin
                    unit_cnt_reg <= unit_cnt_reg + 8'h01;
                end
            end
        end
    end

    assign timeout_abort = abort_reg;

    ////////////////////////////////////////////////////////////////////////
    // Arbitration retry

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            retry_state_reg <= bridge_pkg::RETRY_IDLE;
            restart_reg     <= 1'b0;
        end else begin
            restart_reg <= 1'b0;
            case (retry_state_reg)
                bridge_pkg::RETRY_IDLE: begin
                    if (arb_lost && xfer_active && !timed_out_reg) begin
                        retry_state_reg <= bridge_pkg::RETRY_WAIT_FREE;
                    end
                end
                bridge_pkg::RETRY_WAIT_FREE: begin
                    if (timed_out_reg || abort_reg || !xfer_active) begin
                        retry_state_reg <= bridge_pkg::RETRY_IDLE;
                    end else if (bus_free) begin
                        restart_reg     <= 1'b1;
                        retry_state_reg <= bridge_pkg::RETRY_IDLE;
                    end
                end
                default: begin
                    retry_state_reg <= bridge_pkg::RETRY_IDLE;
                end
            endcase
        end
    end

    assign restart_start = restart_reg;

    ////////////////////////////////////////////////////////////////////////
    // Status and interrupt

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_reg <= `RST_BUS_TRANSACTION_STAT;
        end else if (abort_reg) begin
            status_reg <= `STATUS_TIMEOUT_CODE;
        end else if (status_load) begin
            status_reg <= status_code;
        end
    end

    assign int_set = abort_reg | (status_load & status_irq);

    // A new event in the read cycle wins over the release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_pending_reg <= 1'b0;
        end else if (int_set) begin
            int_pending_reg <= 1'b1;
        end else if (rd_en && index == `REG_BUS_TRANSACTION_STAT) begin
            int_pending_reg <= 1'b0;
        end
    end

    assign int_n_out = 1'b0;
    assign int_n_oe  = int_pending_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_ack_single;
        @(posedge clk) disable iff (rst)
        wb_ack |=> !wb_ack;
    endproperty
    a_ack_single: assert property (p_ack_single)
        else $error("ack held longer than one cycle");

    property p_push_pull;
        @(posedge clk) disable iff (rst)
        pin_type_config_reg[1:0] == `PIN_TYPE_PUSH_PULL
            |-> pin_oe[0] && pin_out[0] == pin_latch_reg[0];
    endproperty
    a_push_pull: assert property (p_push_pull)
        else $error("push-pull pin not driving its latch");

    property p_open_drain;
        @(posedge clk) disable iff (rst)
        pin_type_config_reg[3:2] == `PIN_TYPE_OPEN_DRAIN
            |-> !pin_out[1] && pin_oe[1] == !pin_latch_reg[1]
                && !pin_pullup_en[1];
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin drive wrong");

    property p_input_only;
        @(posedge clk) disable iff (rst)
        !pin_type_config_reg[5] |-> !pin_oe[2];
    endproperty
    a_input_only: assert property (p_input_only)
        else $error("input-only pin is driven");

    property p_timeout_post;
        @(posedge clk) disable iff (rst)
        timeout_abort |=> status_reg == `STATUS_TIMEOUT_CODE && int_n_oe;
    endproperty
    a_timeout_post: assert property (p_timeout_post)
        else $error("timeout not posted");

    property p_int_release;
        @(posedge clk) disable iff (rst)
        rd_en && index == `REG_BUS_TRANSACTION_STAT && !int_set
            |=> !int_n_oe;
    endproperty
    a_int_release: assert property (p_int_release)
        else $error("interrupt not released by status read");

    property p_timeout_disabled;
        @(posedge clk) disable iff (rst)
        !timeout_en [*2] |-> !timeout_abort;
    endproperty
    a_timeout_disabled: assert property (p_timeout_disabled)
        else $error("timeout fired while disabled");

    property p_retry_on_free;
        @(posedge clk) disable iff (rst)
        retry_state_reg == bridge_pkg::RETRY_WAIT_FREE && bus_free
            && xfer_active && !timed_out_reg && !abort_reg
            |=> restart_start ##1 !restart_start;
    endproperty
    a_retry_on_free: assert property (p_retry_on_free)
        else $error("no restart once bus went free");

    property p_level_reserved;
        @(posedge clk) disable iff (rst)
        rd_en && index == `REG_PIN_LEVEL |=> wb_ack && wb_dat_r[31:5] == 0;
    endproperty
    a_level_reserved: assert property (p_level_reserved)
        else $error("reserved level bits not zero");

    property p_level_write;
        @(posedge clk) disable iff (rst)
        wr_en && index == `REG_PIN_LEVEL
            |=> pin_latch_reg == $past(wb_dat_w[3:0]);
    endproperty
    a_level_write: assert property (p_level_write)
        else $error("pin latch not loaded");

    c_timeout: cover property (@(posedge clk) disable iff (rst)
        timeout_abort);
    c_restart: cover property (@(posedge clk) disable iff (rst)
        restart_start);
    c_status_read: cover property (@(posedge clk) disable iff (rst)
        int_n_oe ##1 rd_en && index == `REG_BUS_TRANSACTION_STAT);

endmodule

// ---- testbench/pin_world.sv ----
`timescale 1ns/1ps

module pin_world (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    input  wire logic [4:0] ext_level,
    output logic      [4:0] pin_level
);
    // A released pin shows the board's own level, never the last drive
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
        pin_level[4] = ext_level[4];
    end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
    logic        clk;
    logic        rst;
    logic        wb_cyc, wb_stb, wb_we;
    logic [7:0]  wb_adr;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic [3:0]  wb_sel, pin_out, pin_oe, pin_pullup_en, lv, e;
    logic        wb_ack, xfer_active, arb_lost, bus_free;
    logic        status_load, status_irq, restart_start, timeout_abort;
    logic        int_n_out, int_n_oe, scl_tick;
    logic [6:0]  own;
    logic [7:0]  status_code, d;
    logic [4:0]  ext, pin_in;
    logic [7:0]  exp_q[$];
    int          error_cnt, comparisons, n, m, seed;

    spi_i2c_bridge_config_regs dut (.clk(clk), .rst(rst), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_dat_w(wb_dat_w), .wb_sel(wb_sel), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
        .xfer_active(xfer_active), .arb_lost(arb_lost),
        .bus_free(bus_free), .status_load(status_load),
        .status_code(status_code), .status_irq(status_irq),
        .restart_start(restart_start), .timeout_abort(timeout_abort),
        .scl_quarter_tick(scl_tick), .own_addr(own),
        .int_n_out(int_n_out),
        .int_n_oe(int_n_oe));
    pin_world world (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext), .pin_level(pin_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] ex);
        comparisons++;
        if (got !== ex) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] v, input logic s);
        int k;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat_w <= {24'h0, v};
        wb_sel <= {3'h0, s};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        if (k >= 50) begin
            error_cnt++;
            tally_and_finish();
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        exp_q.push_back(ex);
        wb(1'b0, a, 8'h00, 1'b1);
    endtask

    // Read results are matched against the oldest pending note
    always @(posedge clk) begin
        if (wb_ack === 1'b1 && wb_we === 1'b0) begin
            cmp(wb_dat_r, {24'h0, exp_q.pop_front()});
        end
    end

    task automatic wait_abort(input int lim);
        n = 0;
        while (timeout_abort !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    // Returns one negedge after a quarter tick; n counts the edges waited
    task automatic wait_tick;
        n = 0;
        while (scl_tick !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            error_cnt++;
            tally_and_finish();
        end
        @(negedge clk);
    endtask

    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, wb_sel} = '0;
        {xfer_active, arb_lost, bus_free, status_load, status_irq} = '0;
        status_code = 8'h00;
        error_cnt = 0;
        comparisons = 0;
        seed = 64494;
        ext = 5'h15;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        rd(8'h00, 8'h00);
        rd(8'h04, 8'h15);
        rd(8'h08, 8'h19);
        rd(8'h0C, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h14, 8'h00);
        rd(8'h18, 8'h00);
        $display("test reset values done");
        wb(1'b1, 8'h14, 8'hA5, 1'b1);
        cmp({25'h0, own}, 32'h52);
        rd(8'h14, 8'hA4);
        wb(1'b1, 8'h10, 8'hAA, 1'b1);
        rd(8'h10, 8'h00);
        wb(1'b1, 8'h08, 8'h33, 1'b0);
        rd(8'h08, 8'h19);
        d = 8'd5 + 8'($unsigned($random(seed)) % 251);
        wb(1'b1, 8'h08, d, 1'b1);
        rd(8'h08, d);
        wb(1'b1, 8'h04, 8'hFF, 1'b1);
        repeat (8) @(posedge clk);
        rd(8'h04, 8'h15);
        $display("test register access done");
        for (int c = 0; c < 4; c++) begin
            lv = 4'($random(seed));
            wb(1'b1, 8'h00, {4{2'(c)}}, 1'b1);
            wb(1'b1, 8'h04, {4'h0, lv}, 1'b1);
            e = (c == 2) ? 4'hF : ((c == 3) ? ~lv : 4'h0);
            cmp({28'h0, pin_oe}, {28'h0, e});
            if (c >= 2) begin
                cmp({28'h0, pin_out}, {28'h0, (c == 2) ? lv : 4'h0});
                cmp({28'h0, pin_pullup_en}, {28'h0, (c == 3) ? 4'h0 : 4'hF});
            end
            e = (c == 2) ? lv : ((c == 3) ? (lv & ext[3:0]) : ext[3:0]);
            repeat (8) @(posedge clk);
            rd(8'h04, {3'h0, ext[4], e});
        end
        $display("test pin types done");
        wb(1'b1, 8'h08, 8'h05, 1'b1);
        // Three quarter periods of 2*5 ticks at 15 MHz are 200 clocks
        wait_tick();
        m = 0;
        repeat (3) begin
            wait_tick();
            m += n + 1;
        end
        cmp(m, 32'd200);
        @(posedge clk);
        xfer_active <= 1'b1;
        arb_lost <= 1'b1;
        @(posedge clk);
        arb_lost <= 1'b0;
        wait_abort(21000);
        cmp({31'h0, timeout_abort}, 32'h0);
        n = 0;
        while (restart_start !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        cmp({31'h0, restart_start}, 32'h0);
        @(posedge clk);
        bus_free <= 1'b1;
        n = 0;
        while (restart_start !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        cmp({31'h0, restart_start}, 32'h1);
        if (restart_start !== 1'b1) begin
            tally_and_finish();
        end
        @(posedge clk);
        xfer_active <= 1'b0;
        wb(1'b1, 8'h0C, 8'h01, 1'b1);
        xfer_active <= 1'b1;
        wait_abort(22000);
        cmp((n > 20300 && n < 20700), 32'h1);
        if (timeout_abort !== 1'b1) begin
            tally_and_finish();
        end
        @(negedge clk);
        cmp({30'h0, int_n_oe, int_n_out}, 32'h2);
        @(posedge clk);
        xfer_active <= 1'b0;
        rd(8'h10, 8'hF8);
        @(negedge clk);
        cmp({31'h0, int_n_oe}, 32'h0);
        @(posedge clk);
        $display("test timeout and retry done");
        status_load <= 1'b1;
        status_irq <= 1'b1;
        status_code <= 8'hF1;
        @(posedge clk);
        status_load <= 1'b0;
        @(negedge clk);
        cmp({31'h0, int_n_oe}, 32'h1);
        @(posedge clk);
        rd(8'h10, 8'hF1);
        // A hardware reset in mid-run also releases the interrupt
        status_load <= 1'b1;
        @(posedge clk);
        status_load <= 1'b0;
        @(negedge clk);
        cmp({31'h0, int_n_oe}, 32'h1);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        cmp({31'h0, int_n_oe}, 32'h0);
        @(posedge clk);
        rd(8'h10, 8'h00);
        rd(8'h08, 8'h19);
        $display("test status post done");
        tally_and_finish();
    end
endmodule
